// *** design/emw_device.sv ***
// Device end: external memory cycle sequencer with wait states and bus handover.
// Assumes the core issues one request at a time and holds it until done.
`timescale 1ns/1ps
`default_nettype none
module emw_device (
    input  wire logic                       CLOCK_I,      // 20 MHz clock.
    input  wire logic                       RESETN_I,     // Async reset, active low.
    emw_bus_if.dev                          BUS,          // External memory pins.
    input  wire logic                       EXT_REQ_I,    // Core wants an external access.
    input  wire logic                       EXT_WRITE_I,  // Access is a write.
    input  wire logic [emw_pkg::ADDR_W-1:0] EXT_ADDR_I,   // Word address.
    input  wire logic [emw_pkg::LANES-1:0]  EXT_BYTES_I,  // Bytes to write.
    input  wire logic [emw_pkg::DATA_W-1:0] EXT_WDATA_I,  // Write data.
    output var  logic                       EXT_DONE_O,   // Access finished, one tick.
    output var  logic [emw_pkg::DATA_W-1:0] EXT_RDATA_O,  // Read data.
    input  wire logic                       INT_REQ_I,    // Core on-chip access.
    input  wire logic [emw_pkg::ADDR_W-1:0] INT_ADDR_I,   // On-chip word address.
    output var  logic                       INT_DONE_O,   // On-chip access done, one tick.
    output var  logic                       BOOT_GO_O     // Core may start bootstrap.
);
    // ************************************************************
    // Clock-out divider and request synchroniser.
    // ************************************************************
    logic [1:0]                 ph_q;
    logic                       breq_meta_q;
    logic                       breq_q;
    emw_pkg::emw_state_type     st_q;
    emw_pkg::emw_state_type     st_d;
    logic                       write_q;
    logic [emw_pkg::ADDR_W-1:0] ext_addr_q;
    logic [emw_pkg::LANES-1:0]  bytes_q;
    logic [emw_pkg::DATA_W-1:0] wdata_q;
    logic                       grab_q;
    logic                       armed_q;
    logic                       boot_q;

    wire cycle_end = (ph_q == emw_pkg::PH_LAST);
    wire high_end  = (ph_q == emw_pkg::PH_HIGH_END);
    wire half_end  = ph_q[0];
    wire [1:0] ph_d = ph_q + 2'h1;
    // The request pin is asynchronous, so it passes two flops first.
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ph_q        <= emw_pkg::PH_RISE;
            breq_meta_q <= 1'b0;
            breq_q      <= 1'b0;
        end else begin
            ph_q        <= ph_d;
            breq_meta_q <= BUS.bus_request;
            breq_q      <= breq_meta_q;
        end
    end

    // ************************************************************
    // Bus sequencer.
    // ************************************************************
    // Start an external cycle only on a rising clock-out edge with the bus held.
    wire ext_start = EXT_REQ_I && !EXT_DONE_O && !grab_q && boot_q && cycle_end;
    // Handover is sampled in the high phase of phase one or of an idle cycle.
    wire grab_d = ((st_q == emw_pkg::ST_T1) || (st_q == emw_pkg::ST_IDLE)) && high_end
                ? breq_q : grab_q;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            emw_pkg::ST_IDLE: begin
                if (grab_q && ph_q == emw_pkg::PH_RISE)
                    st_d = emw_pkg::ST_HANDOFF;
                else if (ext_start)
                    st_d = emw_pkg::ST_T1;
            end
            emw_pkg::ST_T1: if (half_end) st_d = emw_pkg::ST_T2;
            // Wait is sampled at the end of the data setup phase.
            emw_pkg::ST_T2: if (half_end) st_d = BUS.wait_request ? emw_pkg::ST_W1
                                                  : emw_pkg::ST_T3;
            emw_pkg::ST_W1: if (half_end) st_d = emw_pkg::ST_W2;
            emw_pkg::ST_W2: if (half_end) st_d = BUS.wait_request ? emw_pkg::ST_W1
                                                  : emw_pkg::ST_T3;
            emw_pkg::ST_T3: if (half_end) st_d = emw_pkg::ST_T4;
            emw_pkg::ST_T4: if (half_end) st_d = emw_pkg::ST_IDLE;
            // One quarter with strobes driven high, then float at the falling edge.
            emw_pkg::ST_HANDOFF: if (high_end) st_d = emw_pkg::ST_GRANTED;
            // Reclaim at the falling edge after a low request in the high phase.
            emw_pkg::ST_GRANTED: if (high_end && !breq_q) st_d = emw_pkg::ST_IDLE;
            default: st_d = emw_pkg::ST_IDLE;
        endcase
    end

    // ************************************************************
    // Next pin values, all registered on the way out.
    // ************************************************************
    wire in_cycle  = (st_d == emw_pkg::ST_T1) || (st_d == emw_pkg::ST_T2) ||
                     (st_d == emw_pkg::ST_W1) || (st_d == emw_pkg::ST_W2) ||
                     (st_d == emw_pkg::ST_T3) || (st_d == emw_pkg::ST_T4);
    wire granted_d = (st_d == emw_pkg::ST_GRANTED);
    // Chip enable falls one quarter into phase one and rises at the end of hold.
    wire ce_low_d  = in_cycle && !(st_d == emw_pkg::ST_T1 && ph_d == emw_pkg::PH_RISE);
    wire we_low_d  = write_q && ((st_d == emw_pkg::ST_T3) ||
                     (st_d == emw_pkg::ST_T4 && ph_d == emw_pkg::PH_LOW_BEGIN));
    wire drive_d   = write_q && in_cycle && (st_d != emw_pkg::ST_T1);
    // Outside a cycle the address shows the on-chip word being used.
    wire [emw_pkg::ADDR_W-1:0] addr_d = in_cycle ? ext_addr_q : INT_ADDR_I;
    // On-chip accesses take one processor cycle whatever the wait pin does.
    wire int_done_d = INT_REQ_I && !INT_DONE_O && cycle_end;
    wire ext_done_d = (st_q == emw_pkg::ST_T4) && (st_d == emw_pkg::ST_IDLE);
    wire capture    = (st_q == emw_pkg::ST_T4) && (ph_q == emw_pkg::PH_READ_CAPTURE);
    // Boot waits one full cycle so the synchronised request has settled.
    wire boot_d = boot_q || (armed_q && high_end && !breq_q && st_q == emw_pkg::ST_IDLE);

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st_q    <= emw_pkg::ST_IDLE;
            grab_q  <= 1'b0;
            armed_q <= 1'b0;
            boot_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            grab_q  <= grab_d && (st_d != emw_pkg::ST_GRANTED);
            armed_q <= armed_q || cycle_end;
            boot_q  <= boot_d;
        end
    end

    // Latch the request at the start of each external cycle.
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            write_q    <= 1'b0;
            ext_addr_q <= '0;
            bytes_q    <= '0;
            wdata_q    <= '0;
        end else if (ext_start) begin
            write_q    <= EXT_WRITE_I;
            ext_addr_q <= EXT_ADDR_I;
            bytes_q    <= EXT_BYTES_I;
            wdata_q    <= EXT_WDATA_I;
        end
    end

    // Pin registers; address and strobes float only while the bus is away.
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            BUS.proc_clock_out_a           <= 1'b1;
            BUS.bus_granted                <= 1'b0;
            BUS.addr_dev                   <= '0;
            BUS.addr_dev_oe                <= 1'b1;
            BUS.chip_enable_n_dev          <= 1'b1;
            BUS.chip_enable_n_dev_oe       <= 1'b1;
            BUS.byte_write_enable_n_dev    <= '1;
            BUS.byte_write_enable_n_dev_oe <= 1'b1;
            BUS.data_dev                   <= '0;
            BUS.data_dev_oe                <= '0;
        end else begin
            BUS.proc_clock_out_a           <= ph_d < emw_pkg::PH_LOW_BEGIN;
            BUS.bus_granted                <= granted_d;
            BUS.addr_dev                   <= addr_d;
            BUS.addr_dev_oe                <= !granted_d;
            BUS.chip_enable_n_dev          <= !ce_low_d;
            BUS.chip_enable_n_dev_oe       <= !granted_d;
            BUS.byte_write_enable_n_dev    <= we_low_d ? ~bytes_q : '1;
            BUS.byte_write_enable_n_dev_oe <= !granted_d;
            BUS.data_dev                   <= wdata_q;
            BUS.data_dev_oe                <= drive_d ? bytes_q : '0;
        end
    end

    // Core-side answers.
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            EXT_DONE_O  <= 1'b0;
            EXT_RDATA_O <= '0;
            INT_DONE_O  <= 1'b0;
            BOOT_GO_O   <= 1'b0;
        end else begin
            EXT_DONE_O  <= ext_done_d;
            INT_DONE_O  <= int_done_d;
            BOOT_GO_O   <= boot_d;
            if (capture && !write_q)
                EXT_RDATA_O <= BUS.data_bus;
        end
    end
endmodule : emw_device
`default_nettype wire

// *** design/emw_pkg.sv ***
// Package for the external memory wait-state and bus handover block.
// Assumes one 20 MHz clock; each processor cycle is four clock ticks.
package emw_pkg;
    // ************************************************************
    // Bus widths and clock division.
    // ************************************************************
    localparam int ADDR_W = 30;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int CLK_PERIOD_NS = 50;
    // One processor cycle spans four ticks, so a bus phase is two ticks.
    localparam int PROC_CYCLE_NS = 200;
    localparam int TICKS_PER_CYCLE = PROC_CYCLE_NS / CLK_PERIOD_NS;
    localparam logic [1:0] PH_RISE = 2'h0;
    localparam logic [1:0] PH_HIGH_END = 2'h1;
    localparam logic [1:0] PH_LOW_BEGIN = 2'h2;
    localparam logic [1:0] PH_LAST = 2'(TICKS_PER_CYCLE - 1);
    // Read data is captured in the middle of the hold phase.
    localparam logic [1:0] PH_READ_CAPTURE = 2'h2;
    // Length of a master access while it owns the bus, in ticks.
    localparam logic [2:0] MST_ACCESS_TICKS = 3'h4;

    // ************************************************************
    // Device bus sequencer states.
    // ************************************************************
    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_T1      = 9'h002,
        ST_T2      = 9'h004,
        ST_W1      = 9'h008,
        ST_W2      = 9'h010,
        ST_T3      = 9'h020,
        ST_T4      = 9'h040,
        ST_HANDOFF = 9'h080,
        ST_GRANTED = 9'h100
    } emw_state_type;
endpackage : emw_pkg

// *** design/emw_bus_if.sv ***
// Interface joining the device end and the bus master end.
// Assumes both ends share CLOCK_I; resolves every shared pin from its enables.
`timescale 1ns/1ps
`default_nettype none
interface emw_bus_if;
    // ************************************************************
    // Pin drives from each end.
    // ************************************************************
    logic [emw_pkg::ADDR_W-1:0] addr_dev;
    logic                       addr_dev_oe;
    logic [emw_pkg::ADDR_W-1:0] addr_mst;
    logic                       addr_mst_oe;
    logic [emw_pkg::DATA_W-1:0] data_dev;
    logic [emw_pkg::LANES-1:0]  data_dev_oe;
    logic [emw_pkg::DATA_W-1:0] data_mst;
    logic                       data_mst_oe;
    logic                       chip_enable_n_dev;
    logic                       chip_enable_n_dev_oe;
    logic                       chip_enable_n_mst;
    logic                       chip_enable_n_mst_oe;
    logic [emw_pkg::LANES-1:0]  byte_write_enable_n_dev;
    logic                       byte_write_enable_n_dev_oe;
    logic [emw_pkg::LANES-1:0]  byte_write_enable_n_mst;
    logic                       byte_write_enable_n_mst_oe;
    logic                       wait_request;
    logic                       bus_request;
    logic                       bus_granted;
    logic                       proc_clock_out_a;

    // ************************************************************
    // Resolved levels; undriven strobes read high as with a pull-up.
    // ************************************************************
    logic [emw_pkg::ADDR_W-1:0] addr_bus;
    logic [emw_pkg::DATA_W-1:0] data_bus;
    logic                       chip_enable_n;
    logic [emw_pkg::LANES-1:0]  byte_write_enable_n;
    assign addr_bus = addr_dev_oe ? addr_dev : (addr_mst_oe ? addr_mst : '0);
    assign chip_enable_n = chip_enable_n_dev_oe ? chip_enable_n_dev
                         : (chip_enable_n_mst_oe ? chip_enable_n_mst : 1'b1);
    assign byte_write_enable_n = byte_write_enable_n_dev_oe ? byte_write_enable_n_dev
                         : (byte_write_enable_n_mst_oe ? byte_write_enable_n_mst : '1);
    for (genvar g = 0; g < emw_pkg::LANES; g++) begin : g_lane
        assign data_bus[g*8 +: 8] = data_dev_oe[g] ? data_dev[g*8 +: 8]
                                  : (data_mst_oe ? data_mst[g*8 +: 8] : 8'h00);
    end
    modport dev (
        output addr_dev, addr_dev_oe, data_dev, data_dev_oe,
        output chip_enable_n_dev, chip_enable_n_dev_oe,
        output byte_write_enable_n_dev, byte_write_enable_n_dev_oe,
        output bus_granted, proc_clock_out_a,
        input  data_bus, wait_request, bus_request
    );
    modport mst (
        output addr_mst, addr_mst_oe, data_mst, data_mst_oe,
        output chip_enable_n_mst, chip_enable_n_mst_oe,
        output byte_write_enable_n_mst, byte_write_enable_n_mst_oe,
        output wait_request, bus_request,
        input  data_bus, chip_enable_n, bus_granted, proc_clock_out_a
    );
endinterface : emw_bus_if
`default_nettype wire

// *** design/emw_master.sv ***
// Far end: bus master that requests the bus, plus a wait-state generator.
// Assumes the same clock as the device, so bus pins need no synchroniser.
`timescale 1ns/1ps
`default_nettype none
module emw_master #(
    parameter int WAIT_W = 4                            // Width of wait count.
) (
    input  wire logic                       CLOCK_I,    // 20 MHz clock.
    input  wire logic                       RESETN_I,   // Async reset, active low.
    emw_bus_if.mst                          BUS,        // External memory pins.
    input  wire logic [WAIT_W-1:0]          WAITS_I,    // Wait states per cycle.
    input  wire logic                       WANT_BUS_I, // Hold the bus request.
    input  wire logic                       GO_I,       // Start one access.
    input  wire logic                       WRITE_I,    // Access is a write.
    input  wire logic [emw_pkg::ADDR_W-1:0] ADDR_I,     // Word address.
    input  wire logic [emw_pkg::DATA_W-1:0] WDATA_I,    // Write data.
    output var  logic                       OWNED_O,    // Bus ownership seen.
    output var  logic                       DONE_O,     // Access done, one tick.
    output var  logic [emw_pkg::DATA_W-1:0] RDATA_O     // Read data.
);
    // ************************************************************
    // Wait generator.
    // ************************************************************
    logic              ce_n_q;
    logic              pclk_q;
    logic [WAIT_W-1:0] wcnt_q;
    logic [2:0]        acc_q;

    wire ce_fall   = ce_n_q && !BUS.chip_enable_n;
    wire pclk_rise = !pclk_q && BUS.proc_clock_out_a;
    // A delay line started by chip enable; one count per processor cycle.
    wire [WAIT_W-1:0] wcnt_d = ce_fall ? WAITS_I
                             : (pclk_rise && wcnt_q != '0) ? wcnt_q - WAIT_W'(1) : wcnt_q;

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ce_n_q           <= 1'b1;
            pclk_q           <= 1'b1;
            wcnt_q           <= '0;
            BUS.wait_request <= 1'b0;
        end else begin
            ce_n_q           <= BUS.chip_enable_n;
            pclk_q           <= BUS.proc_clock_out_a;
            wcnt_q           <= wcnt_d;
            BUS.wait_request <= wcnt_d != '0;
        end
    end

    // ************************************************************
    // Bus master.
    // ************************************************************
    // Ownership is taken on a rising clock-out edge, never mid phase.
    wire owned_d = pclk_rise ? BUS.bus_granted : (OWNED_O && BUS.bus_granted);
    wire acc_go  = GO_I && OWNED_O && acc_q == '0;
    wire [2:0] acc_d = acc_go ? emw_pkg::MST_ACCESS_TICKS
                     : (acc_q != '0) ? acc_q - 3'h1 : acc_q;

    // Reset floats the address, data and strobe pins so a cut-off transfer leaves no drive.
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            BUS.bus_request                <= 1'b0;
            OWNED_O                        <= 1'b0;
            acc_q                          <= '0;
            DONE_O                         <= 1'b0;
            RDATA_O                        <= '0;
            BUS.addr_mst                   <= '0;
            BUS.addr_mst_oe                <= 1'b0;
            BUS.data_mst                   <= '0;
            BUS.data_mst_oe                <= 1'b0;
            BUS.chip_enable_n_mst          <= 1'b1;
            BUS.chip_enable_n_mst_oe       <= 1'b0;
            BUS.byte_write_enable_n_mst    <= '1;
            BUS.byte_write_enable_n_mst_oe <= 1'b0;
        end else begin
            BUS.bus_request                <= WANT_BUS_I || acc_q != '0;
            OWNED_O                        <= owned_d;
            acc_q                          <= acc_d;
            DONE_O                         <= acc_q == 3'h1;
            if (acc_q == 3'h1 && !BUS.byte_write_enable_n_mst_oe)
                RDATA_O <= BUS.data_bus;
            if (acc_go) begin
                BUS.addr_mst                <= ADDR_I;
                BUS.data_mst                <= WDATA_I;
                BUS.byte_write_enable_n_mst <= WRITE_I ? '0 : '1;
            end else if (acc_q == 3'h1) begin
                BUS.byte_write_enable_n_mst <= '1; // Strobes rise at the end so no stray write.
            end
            BUS.addr_mst_oe                <= owned_d;
            BUS.chip_enable_n_mst_oe       <= owned_d;
            BUS.byte_write_enable_n_mst_oe <= owned_d && (acc_go ? WRITE_I
                                              : !(&BUS.byte_write_enable_n_mst));
            BUS.chip_enable_n_mst          <= !(acc_d != '0);
            BUS.data_mst_oe                <= owned_d && acc_d != '0 && (acc_go ? WRITE_I
                                              : !(&BUS.byte_write_enable_n_mst));
        end
    end
endmodule : emw_master
`default_nettype wire

// *** tb/emw_chk_sva.sv ***
// Checker for the wait-state and bus handover pins of the external memory bus.
// Assumes it stands beside the interface instance and sees its signals as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module emw_chk (
    input wire logic                      CLOCK_I,                    // Clock.
    input wire logic                      RESETN_I,                   // Reset, active low.
    input wire logic                      bus_request,                // Master asks for bus.
    input wire logic                      wait_request,               // Wait from generator.
    input wire logic                      bus_granted,                // Bus handed over.
    input wire logic                      proc_clock_out_a,           // Processor clock pin.
    input wire logic                      addr_dev_oe,                // Device drives address.
    input wire logic [emw_pkg::LANES-1:0] data_dev_oe,                // Device drives data.
    input wire logic                      chip_enable_n_dev,          // Device enable level.
    input wire logic                      chip_enable_n_dev_oe,       // Device drives enable.
    input wire logic [emw_pkg::LANES-1:0] byte_write_enable_n_dev,    // Device write enables.
    input wire logic                      byte_write_enable_n_dev_oe  // Device drives them.
);
    // ************************************************************
    // Helper logic and properties.
    // ************************************************************
    // A stretched cycle must last whole processor cycles, so the low time is counted.
    logic [7:0] low_q;
    wire        ce_low = chip_enable_n_dev_oe && !chip_enable_n_dev;
    wire        idle_hi = chip_enable_n_dev_oe && chip_enable_n_dev && byte_write_enable_n_dev_oe
                        && (&byte_write_enable_n_dev);
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) low_q <= 8'h00;
        else low_q <= ce_low ? low_q + 8'h01 : 8'h00;
    end
    // All properties share the one clock and its reset.
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);
    chk_pclk_shape: assert property ($rose(proc_clock_out_a) |->
        proc_clock_out_a[*2] ##1 !proc_clock_out_a[*2] ##1 proc_clock_out_a) else $error("pclk");
    chk_grant_on_fall: assert property ($changed(bus_granted) |->
        $fell(proc_clock_out_a)) else $error("grant moved off falling clock edge");
    chk_bus_off_grant: assert property (bus_granted |-> !addr_dev_oe &&
        data_dev_oe == 4'h0 && !chip_enable_n_dev_oe && !byte_write_enable_n_dev_oe)
        else $error("device drives bus while granted");
    chk_handoff_high: assert property ($rose(bus_granted) |-> $past(idle_hi))
        else $error("strobes not high before tristate");
    chk_reclaim_idle: assert property ($fell(bus_granted) |-> idle_hi && addr_dev_oe)
        else $error("bus not reclaimed idle");
    chk_release_time: assert property ($fell(bus_request) && bus_granted |->
        ##[1:8] !bus_granted) else $error("bus not returned in time");
    chk_grant_time: assert property ($rose(bus_request) && !wait_request |->
        ##[1:24] bus_granted) else $error("grant too late");
    chk_enable_len: assert property ($fell(ce_low) |->
        low_q[1:0] == 2'h3 && low_q >= 8'h07) else $error("enable low time not whole cycles");
    chk_data_idle: assert property (chip_enable_n_dev && $past(chip_enable_n_dev) &&
        !bus_granted |-> data_dev_oe == 4'h0) else $error("data driven while idle");
    cover property ($rose(bus_granted));
    cover property ($fell(bus_granted));
    cover property ($fell(ce_low) && low_q > 8'h07);
endmodule : emw_chk
`default_nettype wire

// *** tb/tb_ext_mem_wait_and_bus_grant.sv ***
// Self-checking bench for the device and master ends joined by one bus interface.
// Assumes the package, the interface and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_ext_mem_wait_and_bus_grant;
    // ************************************************************
    // Stimulus, the two ends and the checker.
    // ************************************************************
    `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
        $display("BAD %s expected %h seen %h", nm, e, g); end end
    logic                       clk, rst_n, mrst_n, ext_req, ext_wr, int_req, want, go;
    logic                       ext_done, int_done, boot_go, owned, mdone;
    logic [emw_pkg::ADDR_W-1:0] ext_addr, int_addr, maddr;
    logic [emw_pkg::DATA_W-1:0] wdata, rdata, mrdata, d_seen;
    logic [3:0]                 bytes, waits, we_seen;
    int                         mismatches, checks_done, n;
    emw_bus_if bus ();
    emw_device u_emw_device (.CLOCK_I(clk), .RESETN_I(rst_n), .BUS(bus.dev), .EXT_REQ_I(ext_req),
        .EXT_WRITE_I(ext_wr), .EXT_ADDR_I(ext_addr), .EXT_BYTES_I(bytes), .EXT_WDATA_I(wdata),
        .EXT_DONE_O(ext_done), .EXT_RDATA_O(rdata), .INT_REQ_I(int_req), .INT_ADDR_I(int_addr),
        .INT_DONE_O(int_done), .BOOT_GO_O(boot_go));
    emw_master #(.WAIT_W(4)) u_emw_master (.CLOCK_I(clk), .RESETN_I(mrst_n), .BUS(bus.mst),
        .WAITS_I(waits), .WANT_BUS_I(want), .GO_I(go), .WRITE_I(ext_wr), .ADDR_I(maddr),
        .WDATA_I(wdata), .OWNED_O(owned), .DONE_O(mdone), .RDATA_O(mrdata));
    emw_chk u_emw_chk (.CLOCK_I(clk), .RESETN_I(rst_n), .bus_request(bus.bus_request),
        .wait_request(bus.wait_request), .bus_granted(bus.bus_granted),
        .proc_clock_out_a(bus.proc_clock_out_a), .addr_dev_oe(bus.addr_dev_oe),
        .data_dev_oe(bus.data_dev_oe), .chip_enable_n_dev(bus.chip_enable_n_dev),
        .chip_enable_n_dev_oe(bus.chip_enable_n_dev_oe),
        .byte_write_enable_n_dev(bus.byte_write_enable_n_dev),
        .byte_write_enable_n_dev_oe(bus.byte_write_enable_n_dev_oe));
    // Inputs move 2 ns after the rising edge so no sampling race is possible.
    task automatic tick(); @(posedge clk); #2; endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic give_up(input logic ok);
        if (!ok) begin
            mismatches++;
            report_and_stop();
        end
    endtask : give_up
    // One external access; records what the write enables and data lanes showed.
    task automatic ext_access(input logic w, input logic [3:0] b, output int t);
        tick();
        ext_wr = w;
        bytes = b;
        we_seen = 4'hf;
        ext_req = 1'b1;
        for (t = 0; t < 200 && ext_done !== 1'b1; t++) begin
            tick();
            if (bus.byte_write_enable_n !== 4'hf) begin
                we_seen = bus.byte_write_enable_n;
                d_seen = bus.data_bus;
            end
        end
        ext_req = 1'b0;
        give_up(t < 200);
    endtask : ext_access
    // Writes with zero to two wait states; only two byte lanes are written.
    task automatic s_waits();
        int t[3];
        for (int k = 0; k < 3; k++) begin
            waits = 4'(k);
            ext_access(1'b1, 4'h5, t[k]);
            `CHK("write enables", 4'ha, we_seen)
            `CHK("write lanes", 32'h00220044, d_seen)
        end
        `CHK("wait adds whole cycles", 0, (t[2] - t[1]) % 4)
        `CHK("waits keep stretching", 1'b1, t[2] > t[1] && t[1] > t[0])
        ext_access(1'b0, 4'hf, n);
        `CHK("read leaves write enables", 4'hf, we_seen)
        `CHK("read data of floating bus", 32'h0, rdata)
    endtask : s_waits
    // On-chip access ignores a nonzero wait setting and shows its address.
    task automatic s_internal();
        waits = 4'h3;
        int_addr = 30'h00000abc;
        repeat (2) tick();
        `CHK("idle address", int_addr, bus.addr_bus)
        int_req = 1'b1;
        for (n = 0; n < 6 && int_done !== 1'b1; n++) tick();
        int_req = 1'b0;
        `CHK("on-chip access time", 1'b1, int_done)
    endtask : s_internal
    // Master takes the bus; the core's external access stalls until the bus returns.
    task automatic s_grant();
        waits = 4'h0;
        want = 1'b1;
        for (n = 0; n < 40 && owned !== 1'b1; n++) tick();
        give_up(owned === 1'b1);
        `CHK("granted pin", 1'b1, bus.bus_granted)
        go = 1'b1;
        tick();
        go = 1'b0;
        for (n = 0; n < 10 && mdone !== 1'b1; n++) tick();
        `CHK("master access done", 1'b1, mdone)
        int_req = 1'b1;
        for (n = 0; n < 6 && int_done !== 1'b1; n++) tick();
        int_req = 1'b0;
        `CHK("on-chip while granted", 1'b1, int_done)
        ext_req = 1'b1;
        for (n = 0; n < 20 && ext_done !== 1'b1; n++) tick();
        `CHK("external access stalls", 1'b0, ext_done)
        want = 1'b0;
        for (n = 0; n < 60 && ext_done !== 1'b1; n++) tick();
        ext_req = 1'b0;
        `CHK("external after return", 1'b1, ext_done)
        `CHK("bus returned", 1'b0, bus.bus_granted)
    endtask : s_grant
    // The request is raised well before the device reset so the bus is granted first.
    task automatic s_boot();
        want = 1'b1;
        for (n = 0; n < 40 && owned !== 1'b1; n++) tick();
        rst_n = 1'b0;
        repeat (3) tick();
        rst_n = 1'b1;
        for (n = 0; n < 20 && bus.bus_granted !== 1'b1; n++) tick();
        `CHK("granted out of reset", 1'b1, bus.bus_granted)
        `CHK("boot held back", 1'b0, boot_go)
        want = 1'b0;
        for (n = 0; n < 40 && boot_go !== 1'b1; n++) tick();
        `CHK("boot after return", 1'b1, boot_go)
    endtask : s_boot
    // Free-running 20 MHz clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Main sequence: reset, wait for boot, then the scenarios.
    initial begin
        {rst_n, mrst_n, ext_req, ext_wr, int_req, want, go} = 7'h00;
        {ext_addr, int_addr, maddr} = {30'h00000040, 30'h0, 30'h00000123};
        {wdata, bytes, waits, we_seen} = {32'h11223344, 4'hf, 4'h0, 4'hf};
        mismatches = 0;
        checks_done = 0;
        repeat (3) tick();
        {rst_n, mrst_n} = 2'h3;
        for (n = 0; n < 20 && boot_go !== 1'b1; n++) tick();
        give_up(boot_go === 1'b1);
        s_waits();
        s_internal();
        s_grant();
        s_boot();
        report_and_stop();
    end
endmodule : tb_ext_mem_wait_and_bus_grant
`default_nettype wire
